/* File: sim/pcs_codec_port_chk.sv */
// Concurrent checks on the pins of the codec serial port, bound to its top module.
`default_nettype none
module pcs_codec_port_chk #(
  parameter int unsigned FRAME_LOSS_CYCLES = 200
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic masterClockIn,
  input wire logic rxBitClock,
  input wire logic txFrameSync,
  input wire logic txPcmOut,
  input wire logic txPcmOe,
  input wire logic txBitClockOrSlotStrobeOut,
  input wire logic txBitClockOrSlotStrobeOe,
  input wire logic powerDownInN
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] lowCnt_q;
  logic [4:0] pdCnt_q;
  logic fixedSeen;
  // Counts master cycles with the receive bit clock low; saturates rather than wrapping.
  always_ff @(posedge masterClockIn or negedge resetn) begin
    if (!resetn) begin
      lowCnt_q <= 6'h00;
    end else if (rxBitClock) begin
      lowCnt_q <= 6'h00;
    end else if (lowCnt_q != 6'h3F) begin
      lowCnt_q <= lowCnt_q + 6'h01;
    end
  end
  // Counts master cycles with the power-down pin low.
  always_ff @(posedge masterClockIn or negedge resetn) begin
    if (!resetn) begin
      pdCnt_q <= 5'h00;
    end else if (powerDownInN) begin
      pdCnt_q <= 5'h00;
    end else if (pdCnt_q != 5'h1F) begin
      pdCnt_q <= pdCnt_q + 5'h01;
    end
  end
  // Margin above the design's detect count, so a late detect never trips the checks.
  assign fixedSeen = (lowCnt_q >= 6'h30);

  a_oe_after_sync: assert property (@(posedge masterClockIn) disable iff (!resetn)
    $rose(txPcmOe) |-> $past(txFrameSync)) else $error("Tx drive without frame sync");
  a_oe_holds_word: assert property (@(posedge masterClockIn) disable iff (!resetn)
    $rose(txPcmOe) |-> txPcmOe [*8]) else $error("Tx drive shorter than a word");
  a_fixed_word_len: assert property (@(posedge masterClockIn) disable iff (!resetn)
    $rose(txPcmOe) && fixedSeen |-> ##[8:10] !txPcmOe) else $error("Fixed slot length wrong");
  a_strobe_fixed_only: assert property (@(posedge masterClockIn) disable iff (!resetn)
    $rose(txBitClockOrSlotStrobeOe) |-> fixedSeen) else $error("Strobe in variable rate");
  a_strobe_with_slot: assert property (@(posedge masterClockIn) disable iff (!resetn)
    $rose(txPcmOe) && fixedSeen |-> ##[0:1] txBitClockOrSlotStrobeOe)
    else $error("Slot strobe missing");
  a_strobe_ends: assert property (@(posedge masterClockIn) disable iff (!resetn)
    $fell(txPcmOe) && fixedSeen |-> ##[0:2] !txBitClockOrSlotStrobeOe)
    else $error("Slot strobe stuck");
  a_strobe_pulls_low: assert property (@(posedge masterClockIn) disable iff (!resetn)
    txBitClockOrSlotStrobeOe |-> !txBitClockOrSlotStrobeOut) else $error("Strobe drives high");
  a_pd_no_slot: assert property (@(posedge masterClockIn) disable iff (!resetn)
    pdCnt_q == 5'h1F |-> !$rose(txPcmOe)) else $error("Slot opened while powered down");
  a_rdata_one_cycle: assert property (@(posedge clock) disable iff (!resetn)
    !$past(regRd) |-> regRdData == 8'h00) else $error("Read data outside its cycle");
endmodule

bind pcs_codec_port pcs_codec_port_chk #(.FRAME_LOSS_CYCLES(FRAME_LOSS_CYCLES)) u_chk (
  .clock(clock), .resetn(resetn), .regRd(regRd), .regRdData(regRdData),
  .masterClockIn(masterClockIn), .rxBitClock(rxBitClock), .txFrameSync(txFrameSync),
  .txPcmOut(txPcmOut), .txPcmOe(txPcmOe), .txBitClockOrSlotStrobeOut(txBitClockOrSlotStrobeOut),
  .txBitClockOrSlotStrobeOe(txBitClockOrSlotStrobeOe), .powerDownInN(powerDownInN)
);
`default_nettype wire

/* File: sim/pcs_codec_port_tb.sv */
// Self-checking bench for the codec serial port against the highway model.
`default_nettype none
`include "pcs_regs.svh"
module pcs_codec_port_tb;
  import pcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned LOSS = 2000;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic mClk, rxBitClock, rxPcmIn, rxFrameSync, txFrameSync;
  logic txPcmOut, txPcmOe, strobeIn, strobeOe;
  logic [1:0] rateStrap = 2'h0;
  logic lawStrap = 1'b1;
  logic powerDownInN = 1'b1;
  logic fixedNow = 1'b1;
  int mismatches = 0;
  int checks_done = 0;
  // System clock, 100 ns period.
  initial begin
    forever #50 clock = ~clock;
  end
  pcs_codec_port #(.FRAME_LOSS_CYCLES(LOSS)) u_dut (
    .clock(clock), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .masterClockIn(mClk),
    .rxBitClock(rxBitClock), .rxPcmIn(rxPcmIn), .rxFrameSync(rxFrameSync),
    .txFrameSync(txFrameSync), .txPcmOut(txPcmOut), .txPcmOe(txPcmOe),
    .txBitClockOrSlotStrobeIn(strobeIn), .txBitClockOrSlotStrobeOut(),
    .txBitClockOrSlotStrobeOe(strobeOe), .clockRateStrap(rateStrap),
    .compandingLawStrap(lawStrap), .powerDownInN(powerDownInN));
  pcs_highway_model u_hw (
    .masterClockIn(mClk), .rxBitClock(rxBitClock), .rxPcmIn(rxPcmIn),
    .rxFrameSync(rxFrameSync), .txFrameSync(txFrameSync), .txBitClockOrSlotStrobeIn(strobeIn),
    .txPcmOut(txPcmOut), .txPcmOe(txPcmOe), .txBitClockOrSlotStrobeOe(strobeOe));

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic regWrite(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  task automatic regRead(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  // Straps are tied while reset is held, as a board would have them.
  task automatic doReset(input logic [1:0] rate, input logic law);
    resetn <= 1'b0;
    rateStrap <= rate;
    lawStrap <= law;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    repeat (120) @(posedge clock);
  endtask
  // Expected status: rate, A-law flag, fixed flag, both power-down flags, new-word flag.
  function automatic logic [7:0] stat(input logic pd, input logic newWord);
    return {1'b0, rateStrap, lawStrap == PCS_LAW_A, fixedNow, pd, pd, newWord};
  endfunction
  // A first frame wakes sides that powered down; the second one is checked.
  task automatic xfer(input logic [7:0] txWord, input logic [7:0] rxWord);
    logic [7:0] got;
    logic [7:0] rd;
    int n;
    regWrite(`PCS_ADDR_TX_DATA, txWord);
    u_hw.frame(8'h00, got, n);
    u_hw.frame(rxWord, got, n);
    check(8'(n), 8'h08);
    check(got, txWord ^ ((lawStrap == PCS_LAW_A) ? `PCS_ADI_MASK : 8'h00));
    regRead(`PCS_ADDR_STATUS, rd);
    check(rd, stat(1'b0, 1'b1));
    regRead(`PCS_ADDR_RX_DATA, rd);
    check(rd, rxWord);
  endtask

  initial begin
    logic [7:0] rd;
    logic [7:0] got;
    int n;
    for (int i = 0; i < 3; i++) begin
      doReset(i[1:0], i[0] ? PCS_LAW_MU : PCS_LAW_A);
      regRead(`PCS_ADDR_STATUS, rd);
      check(rd, stat(1'b0, 1'b0));
      xfer(8'hA3 + 8'(i), 8'h5C - 8'(i));
    end
    // Software force puts both sides down and reads back; it is lifted again at once.
    regWrite(`PCS_ADDR_CTRL, 8'h01);
    regRead(`PCS_ADDR_STATUS, rd);
    check(rd, stat(1'b1, 1'b0));
    regRead(`PCS_ADDR_CTRL, rd);
    check(rd, 8'h01);
    regWrite(`PCS_ADDR_CTRL, 8'h00);
    regRead(3'h5, rd);
    check(rd, 8'h00);
    u_hw.varRate = 1'b1;
    fixedNow = 1'b0;
    xfer(8'h81, 8'h3E);
    // With the pin low a frame must move nothing and leave no new word.
    powerDownInN <= 1'b0;
    repeat (20) @(posedge clock);
    u_hw.frame(8'hC3, got, n);
    check(8'(n), 8'h00);
    regRead(`PCS_ADDR_STATUS, rd);
    check(rd, stat(1'b1, 1'b0));
    powerDownInN <= 1'b1;
    repeat (LOSS + 300) @(posedge clock);
    regRead(`PCS_ADDR_STATUS, rd);
    check(rd, stat(1'b1, 1'b0));
    xfer(8'h0F, 8'hF1);
    conclude();
  end
  // Cuts a hang short; the tests need about 1.7 ms.
  initial begin
    #5ms;
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    conclude();
  end
endmodule
`default_nettype wire

/* File: sim/pcs_highway_model.sv */
// Behavioural highway controller that frames one word each way per frame.
`default_nettype none
module pcs_highway_model (
  output logic masterClockIn,
  output logic rxBitClock,
  output logic rxPcmIn,
  output logic rxFrameSync,
  output logic txFrameSync,
  output logic txBitClockOrSlotStrobeIn,
  input wire logic txPcmOut,
  input wire logic txPcmOe,
  input wire logic txBitClockOrSlotStrobeOe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic varRate = 1'b0;
  logic bitClk = 1'b1;
  // Free-running master clock, phase offset from the system clock on purpose.
  initial begin
    masterClockIn = 1'b0;
    rxPcmIn = 1'b0;
    rxFrameSync = 1'b0;
    txFrameSync = 1'b0;
    #37;
    forever #80 masterClockIn = ~masterClockIn;
  end
  // Bit clock idles high, since a low idle would look like fixed rate; pin has a pull-up.
  assign rxBitClock = varRate & bitClk;
  assign txBitClockOrSlotStrobeIn = txBitClockOrSlotStrobeOe ? 1'b0 : (varRate ? bitClk : 1'b1);
  // Both syncs rise together and stay high eight bit times; data changes on rising bit clock.
  task automatic frame(input logic [7:0] rxByte, output logic [7:0] txByte, output int nTx);
    time t0;
    @(posedge masterClockIn);
    t0 = $time;
    nTx = 0;
    txByte = 8'h00;
    rxFrameSync <= 1'b1;
    txFrameSync <= 1'b1;
    rxPcmIn <= rxByte[7];
    for (int k = 0; k < 12; k++) begin
      if (varRate) begin
        repeat (6) @(posedge masterClockIn);
        bitClk <= 1'b0;
      end
      @(negedge masterClockIn);
      if (txPcmOe === 1'b1 && nTx < 8) begin
        txByte = {txByte[6:0], txPcmOut};
        nTx++;
      end
      repeat (varRate ? 6 : 1) @(posedge masterClockIn);
      bitClk <= 1'b1;
      if (k < 7) rxPcmIn <= rxByte[6 - k];
      if (k == 7) begin
        rxFrameSync <= 1'b0;
        txFrameSync <= 1'b0;
      end
    end
    rxPcmIn <= ~rxPcmIn;
    while ($time < t0 + 125000) @(posedge masterClockIn);
  endtask
endmodule
`default_nettype wire

/* File: verilog/pcs_codec_port.sv */
// Digital serial port and control logic of a voice PCM codec.
// How it works
// - Receive bit clock held low selects fixed rate; otherwise it clocks receive.
// - Receive word captured on eight bit-clock falling edges after frame sync rises.
// - Transmit word shifted on eight bit-clock rising edges after frame sync rises.
// - Transmit output driven only during the active transmit slot.
// - Receive side powers down after frame sync low about 300 ms.
// - Transmit clock pin is input clock, or open-drain slot strobe in fixed rate.
// - Law strap low selects A-law, otherwise mu-law.
// - Fixed rate uses the master clock as both bit clocks.
// - A-law transmit words get alternate digit inversion.
//
// Design decisions made here: the strobed register port and the register offsets.
`default_nettype none
`include "pcs_regs.svh"
module pcs_codec_port #(
  parameter int unsigned FRAME_LOSS_CYCLES = `PCS_FRAME_LOSS_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic masterClockIn,
  input wire logic rxBitClock,
  input wire logic rxPcmIn,
  input wire logic rxFrameSync,
  input wire logic txFrameSync,
  output logic txPcmOut,
  output logic txPcmOe,
  input wire logic txBitClockOrSlotStrobeIn,
  output logic txBitClockOrSlotStrobeOut,
  output logic txBitClockOrSlotStrobeOe,
  input wire logic [1:0] clockRateStrap,
  input wire logic compandingLawStrap,
  input wire logic powerDownInN
);
  import pcs_pkg::*;

  // Frame loss counter: saturates at the limit, cleared while the sync is high.
  function automatic logic [21:0] lossNext(logic [21:0] cnt, logic level);
    logic [21:0] limit;
    limit = FRAME_LOSS_CYCLES[21:0];
    if (level) begin
      return 22'h0;
    end else if (cnt >= limit) begin
      return limit;
    end else begin
      return cnt + 22'h1;
    end
  endfunction

  // Alternate digit inversion applies only under A-law.
  function automatic logic [7:0] adiApply(logic [7:0] w, pcs_law_t law);
    return (law == PCS_LAW_A) ? (w ^ `PCS_ADI_MASK) : w;
  endfunction

  // ---------------- System clock domain ----------------
  logic [1:0] rxFsSys_q;
  logic [1:0] txFsSys_q;
  logic [1:0] pdnSys_q;
  logic [1:0] rateS1_q;
  logic [1:0] rateS2_q;
  logic [1:0] lawSys_q;
  logic [1:0] startup_q;
  pcs_rate_t rate_q;
  pcs_law_t law_q;
  logic [21:0] rxLoss_q;
  logic [21:0] txLoss_q;
  logic rxPd_q;
  logic txPd_q;
  logic forcePd_q;
  logic [7:0] txHold_q;
  logic txTog_q;
  logic [7:0] rxData_q;
  logic rxNew_q;
  logic [2:0] rxTogSys_q;
  logic [1:0] fixedSys_q;
  logic [7:0] rdData_q;
  logic rxWordSeen;
  // Link-domain flops read below: two through synchronisers, the receive word directly.
  logic fixedMode_q;
  logic [7:0] rxHoldLink_q;
  logic rxTogLink_q;

  // Two-flop synchronisers for pins and levels from the link domain.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rxFsSys_q <= 2'h0;
      txFsSys_q <= 2'h0;
      pdnSys_q <= 2'h3;
      rateS1_q <= 2'h0;
      rateS2_q <= 2'h0;
      lawSys_q <= 2'h3;
      fixedSys_q <= 2'h0;
    end else begin
      rxFsSys_q <= {rxFsSys_q[0], rxFrameSync};
      txFsSys_q <= {txFsSys_q[0], txFrameSync};
      pdnSys_q <= {pdnSys_q[0], powerDownInN};
      rateS1_q <= clockRateStrap;
      rateS2_q <= rateS1_q;
      lawSys_q <= {lawSys_q[0], compandingLawStrap};
      fixedSys_q <= {fixedSys_q[0], fixedMode_q};
    end
  end

  // Straps are taken once the synchronisers have filled after reset release.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      startup_q <= 2'h0;
      rate_q <= PCS_RATE_2048;
      law_q <= PCS_LAW_MU;
    end else if (startup_q != 2'h3) begin
      startup_q <= startup_q + 2'h1;
      if (startup_q == 2'h2) begin
        rate_q <= pcs_rate_t'(rateS2_q);
        law_q <= lawSys_q[1] ? PCS_LAW_MU : PCS_LAW_A;
      end
    end
  end

  // Each side watches only its own frame sync, so one lost highway leaves the other running.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rxLoss_q <= 22'h0;
      txLoss_q <= 22'h0;
    end else begin
      rxLoss_q <= lossNext(rxLoss_q, rxFsSys_q[1]);
      txLoss_q <= lossNext(txLoss_q, txFsSys_q[1]);
    end
  end

  // Power state of each side: pin, software force, or frame loss.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rxPd_q <= 1'b0;
      txPd_q <= 1'b0;
    end else begin
      rxPd_q <= !pdnSys_q[1] || forcePd_q ||
                (rxLoss_q >= FRAME_LOSS_CYCLES[21:0]);
      txPd_q <= !pdnSys_q[1] || forcePd_q ||
                (txLoss_q >= FRAME_LOSS_CYCLES[21:0]);
    end
  end

  // Control register write.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      forcePd_q <= 1'b0;
    end else if (regWr && regAddr == `PCS_ADDR_CTRL) begin
      forcePd_q <= regWrData[`PCS_CTRL_FORCE_PD];
    end
  end

  // Transmit word handed over by a toggle; the word is stable long before the toggle lands.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      txHold_q <= `PCS_TX_IDLE;
      txTog_q <= 1'b0;
    end else if (regWr && regAddr == `PCS_ADDR_TX_DATA) begin
      txHold_q <= adiApply(regWrData, law_q);
      txTog_q <= !txTog_q;
    end
  end

  // Receive word arrives by toggle; stage 0 feeds only stage 1.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rxTogSys_q <= 3'h0;
    end else begin
      rxTogSys_q <= {rxTogSys_q[1:0], rxTogLink_q};
    end
  end

  assign rxWordSeen = rxTogSys_q[2] != rxTogSys_q[1];

  // A new word sets the flag even in the cycle that a read clears it.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rxData_q <= `PCS_RX_RESET;
      rxNew_q <= 1'b0;
    end else begin
      if (rxWordSeen) begin
        rxData_q <= rxHoldLink_q;
      end
      if (rxWordSeen) begin
        rxNew_q <= 1'b1;
      end else if (regRd && regAddr == `PCS_ADDR_RX_DATA) begin
        rxNew_q <= 1'b0;
      end
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdData_q <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        `PCS_ADDR_TX_DATA: rdData_q <= txHold_q;
        `PCS_ADDR_RX_DATA: rdData_q <= rxData_q;
        `PCS_ADDR_STATUS: rdData_q <= {1'b0, rate_q, law_q == PCS_LAW_A, fixedSys_q[1],
                                       txPd_q, rxPd_q, rxNew_q};
        `PCS_ADDR_CTRL: rdData_q <= {7'h00, forcePd_q};
        default: rdData_q <= 8'h00;
      endcase
    end else begin
      rdData_q <= 8'h00;
    end
  end

  assign regRdData = rdData_q;

  // ---------------- Master clock (link) domain ----------------
  logic [1:0] linkRst_q;
  logic linkResetn;
  logic [2:0] rxClkL_q;
  logic [2:0] txClkL_q;
  logic [2:0] rxFsL_q;
  logic [2:0] txFsL_q;
  logic [2:0] rxDatL_q;
  logic [1:0] rxPdL_q;
  logic [1:0] txPdL_q;
  logic [2:0] txTogL_q;
  logic [5:0] lowCount_q;
  logic [7:0] txWordLink_q;
  logic slotOe_q;
  pcs_lane_if rxLane ();
  pcs_lane_if txLane ();

  // Reset leaves the link domain only in step with its own clock.
  always_ff @(posedge masterClockIn or negedge resetn) begin
    if (!resetn) begin
      linkRst_q <= 2'h0;
    end else begin
      linkRst_q <= {linkRst_q[0], 1'b1};
    end
  end

  assign linkResetn = linkRst_q[1];

  // Synchronisers; edges are taken only between stages one and two.
  always_ff @(posedge masterClockIn or negedge linkResetn) begin
    if (!linkResetn) begin
      rxClkL_q <= 3'h0;
      txClkL_q <= 3'h0;
      rxFsL_q <= 3'h0;
      txFsL_q <= 3'h0;
      rxDatL_q <= 3'h0;
      rxPdL_q <= 2'h0;
      txPdL_q <= 2'h0;
      txTogL_q <= 3'h0;
    end else begin
      rxClkL_q <= {rxClkL_q[1:0], rxBitClock};
      txClkL_q <= {txClkL_q[1:0], txBitClockOrSlotStrobeIn};
      rxFsL_q <= {rxFsL_q[1:0], rxFrameSync};
      txFsL_q <= {txFsL_q[1:0], txFrameSync};
      rxDatL_q <= {rxDatL_q[1:0], rxPcmIn};
      rxPdL_q <= {rxPdL_q[0], rxPd_q};
      txPdL_q <= {txPdL_q[0], txPd_q};
      txTogL_q <= {txTogL_q[1:0], txTog_q};
    end
  end

  // Fixed rate is taken once the receive clock has sat low for a while; any rise leaves it.
  always_ff @(posedge masterClockIn or negedge linkResetn) begin
    if (!linkResetn) begin
      lowCount_q <= 6'h00;
      fixedMode_q <= 1'b0;
    end else if (rxClkL_q[1]) begin
      lowCount_q <= 6'h00;
      fixedMode_q <= 1'b0;
    end else if (lowCount_q == `PCS_FIXED_DETECT_CYCLES) begin
      fixedMode_q <= 1'b1;
    end else begin
      lowCount_q <= lowCount_q + 6'h01;
    end
  end

  // Latest transmit word from software, taken when its toggle lands.
  always_ff @(posedge masterClockIn or negedge linkResetn) begin
    if (!linkResetn) begin
      txWordLink_q <= `PCS_TX_IDLE;
    end else if (txTogL_q[2] != txTogL_q[1]) begin
      txWordLink_q <= txHold_q;
    end
  end

  // Receive lane: falling bit clock edges, or every master cycle in fixed rate.
  assign rxLane.tick = fixedMode_q ? 1'b1 : (rxClkL_q[2] && !rxClkL_q[1]);
  assign rxLane.frameRise = rxFsL_q[1] && !rxFsL_q[2] && !rxPdL_q[1];
  // Data lags one flop more than the frame edge, so the sign bit meets the first tick.
  assign rxLane.serialIn = rxDatL_q[2];
  assign rxLane.loadWord = 8'h00;

  // Transmit lane: rising bit clock edges, or every master cycle in fixed rate.
  assign txLane.tick = fixedMode_q ? 1'b1 : (txClkL_q[1] && !txClkL_q[2]);
  assign txLane.frameRise = txFsL_q[1] && !txFsL_q[2] && !txPdL_q[1];
  assign txLane.serialIn = 1'b0;
  assign txLane.loadWord = txWordLink_q;

  pcs_serial_lane rxLaneUnit (
    .clock(masterClockIn),
    .resetn(linkResetn),
    .lane(rxLane)
  );

  pcs_serial_lane txLaneUnit (
    .clock(masterClockIn),
    .resetn(linkResetn),
    .lane(txLane)
  );

  // Finished receive word is parked and announced by a toggle.
  always_ff @(posedge masterClockIn or negedge linkResetn) begin
    if (!linkResetn) begin
      rxHoldLink_q <= `PCS_RX_RESET;
      rxTogLink_q <= 1'b0;
    end else if (rxLane.done) begin
      rxHoldLink_q <= rxLane.word;
      rxTogLink_q <= !rxTogLink_q;
    end
  end

  // The slot strobe pulls low only in fixed rate, so a variable rate clock is never fought.
  always_ff @(posedge masterClockIn or negedge linkResetn) begin
    if (!linkResetn) begin
      slotOe_q <= 1'b0;
    end else begin
      slotOe_q <= fixedMode_q && (txLane.busy || txLane.frameRise);
    end
  end

  assign txPcmOut = txLane.serialOut;
  assign txPcmOe = txLane.busy;
  assign txBitClockOrSlotStrobeOut = 1'b0;
  assign txBitClockOrSlotStrobeOe = slotOe_q;
endmodule
`default_nettype wire

/* File: verilog/pcs_lane_if.sv */
// Signals between the port logic and one serial shift lane.
`default_nettype none
interface pcs_lane_if;
  logic tick;
  logic frameRise;
  logic serialIn;
  logic [7:0] loadWord;
  logic serialOut;
  logic busy;
  logic done;
  logic [7:0] word;
  modport lane (input tick, input frameRise, input serialIn, input loadWord,
                output serialOut, output busy, output done, output word);
  modport ctrl (output tick, output frameRise, output serialIn, output loadWord,
                input serialOut, input busy, input done, input word);
endinterface
`default_nettype wire

/* File: verilog/pcs_pkg.sv */
// Types shared by the codec serial port modules.
`default_nettype none
package pcs_pkg;
  typedef enum logic [1:0] {
    PCS_RATE_1536 = 2'h0,
    PCS_RATE_1544 = 2'h1,
    PCS_RATE_2048 = 2'h2,
    PCS_RATE_BAD = 2'h3
  } pcs_rate_t;
  typedef enum logic {
    PCS_LAW_A = 1'b0,
    PCS_LAW_MU = 1'b1
  } pcs_law_t;
endpackage
`default_nettype wire

/* File: verilog/pcs_regs.svh */
// Offsets, field positions, reset values and timing counts of the codec serial port.
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

// Register addresses on the plain register port.
`define PCS_ADDR_TX_DATA 3'h0
`define PCS_ADDR_RX_DATA 3'h1
`define PCS_ADDR_STATUS 3'h2
`define PCS_ADDR_CTRL 3'h3

// Status field positions.
`define PCS_ST_RX_NEW 0
`define PCS_ST_RX_PD 1
`define PCS_ST_TX_PD 2
`define PCS_ST_FIXED 3
`define PCS_ST_ALAW 4
`define PCS_ST_RATE_LO 5
`define PCS_ST_RATE_HI 6

// Control field positions and reset values.
`define PCS_CTRL_FORCE_PD 0
`define PCS_CTRL_RESET 8'h00
`define PCS_TX_IDLE 8'hFF
`define PCS_RX_RESET 8'h00

// Word framing and alternate digit inversion mask.
`define PCS_WORD_BITS 4'h8
`define PCS_ADI_MASK 8'h55

// Timing: frame loss time and system clock rate.
`define PCS_FRAME_LOSS_MS 300
`define PCS_CLOCK_HZ 10000000
`define PCS_FRAME_LOSS_CYCLES (`PCS_FRAME_LOSS_MS * (`PCS_CLOCK_HZ / 1000))

// Master clock cycles with the receive bit clock stuck low before fixed rate is taken.
`define PCS_FIXED_DETECT_CYCLES 6'h20

`endif

/* File: verilog/pcs_serial_lane.sv */
// One eight-bit serial shift lane, used once for transmit and once for receive.
`default_nettype none
`include "pcs_regs.svh"
module pcs_serial_lane (
  input wire logic clock,
  input wire logic resetn,
  pcs_lane_if.lane lane
);
  import pcs_pkg::*;

  logic [7:0] shift_q;
  logic [3:0] count_q;
  logic active_q;
  logic outBit_q;
  logic done_q;
  logic [7:0] word_q;

  // A frame edge restarts the word even mid-slot, so a short frame never wedges the lane.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shift_q <= 8'h00;
      count_q <= 4'h0;
    end else if (lane.frameRise) begin
      shift_q <= lane.loadWord;
      count_q <= `PCS_WORD_BITS;
    end else if (lane.tick && count_q != 4'h0) begin
      shift_q <= {shift_q[6:0], lane.serialIn};
      count_q <= count_q - 4'h1;
    end
  end

  // The slot stays active one tick past the last bit so the eighth bit is held a full bit time.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      active_q <= 1'b0;
    end else if (lane.frameRise) begin
      active_q <= 1'b1;
    end else if (lane.tick && count_q == 4'h0) begin
      active_q <= 1'b0;
    end
  end

  // The sign bit leads from the frame edge; each tick but the last moves on one bit.
  // The eighth bit is therefore held over the last tick rather than replaced by fill.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      outBit_q <= 1'b0;
    end else if (lane.frameRise) begin
      outBit_q <= lane.loadWord[7];
    end else if (lane.tick && count_q > 4'h1) begin
      outBit_q <= shift_q[6];
    end
  end

  // Completed word and its one-cycle strobe.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      done_q <= 1'b0;
      word_q <= 8'h00;
    end else begin
      done_q <= !lane.frameRise && lane.tick && count_q == 4'h1;
      if (!lane.frameRise && lane.tick && count_q == 4'h1) begin
        word_q <= {shift_q[6:0], lane.serialIn};
      end
    end
  end

  assign lane.serialOut = outBit_q;
  assign lane.busy = active_q;
  assign lane.done = done_q;
  assign lane.word = word_q;
endmodule
`default_nettype wire
